// ### rtl/ltsm_pkg.sv
// Constants and carriers for the latch trigger select and monitor block.
// Assumes a single 125 MHz clock domain; command fields arrive already decoded.
package ltsm_pkg;

	// ----------------------------------------
	// Operation type codes
	// ----------------------------------------
	localparam logic [7:0] TYPE_LATCH_ABS = 8'h12;
	localparam logic [7:0] TYPE_LATCH_REL = 8'h13;

	// ----------------------------------------
	// Latch trigger selector values
	// ----------------------------------------
	localparam logic [3:0] SEL_Z_PHASE = 4'h0;
	localparam logic [3:0] SEL_EXTERNAL_INPUT_ONE_RISE = 4'h1;
	localparam logic [3:0] SEL_EXTERNAL_INPUT_TWO_RISE = 4'h2;
	localparam logic [3:0] SEL_EXTERNAL_INPUT_THREE_RISE = 4'h3;
	localparam logic [3:0] SEL_EXTERNAL_INPUT_ONE_FALL = 4'h9;
	localparam logic [3:0] SEL_EXTERNAL_INPUT_TWO_FALL = 4'hA;
	localparam logic [3:0] SEL_EXTERNAL_INPUT_THREE_FALL = 4'hB;

	// ----------------------------------------
	// Command error codes
	// ----------------------------------------
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] ERR_BAD_SELECTOR = 16'h0032;
	localparam logic [15:0] ERR_NO_Z_PHASE = 16'h005A;

	// ----------------------------------------
	// Monitor and response layout
	// ----------------------------------------
	localparam logic [7:0] MON_SEL_LATCHED_POS = 8'h09;
	localparam int RESP_BYTE9_LATCH_DONE_BIT = 0;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic [7:0] type_code;
		logic [3:0] latch_trigger_selector;
		logic [7:0] monitor_sel;
	} ltsm_cmd_t;

	typedef struct packed {
		logic external_input_one;
		logic external_input_two;
		logic external_input_three;
		logic z_phase;
	} ltsm_trig_t;

	typedef enum logic [2:0] {
		LTSM_IDLE = 3'b001,
		LTSM_ARMED = 3'b010,
		LTSM_DONE = 3'b100
	} ltsm_state_t;

endpackage

// ### rtl/ltsm_latch_monitor.sv
// Latch trigger selection, latch capture, latch done flag and monitor data.
// Assumes command fields are presented one cycle per frame by a frame decoder.
//
// Behaviour
// [RULE1] Selector is used only for type codes 12h and 13h.
// [RULE2] Selector 0 latches on Z phase, scale Z phase when full-closed.
// [RULE3] Selector 0 with serial absolute external scale gives error 005Ah.
// [RULE4] Selectors 1, 2, 3 latch on rising edge of inputs one to three.
// [RULE5] Selectors 9, 10, 11 latch on falling edge of inputs one to three.
// [RULE6] Selectors 4 to 8 and 12 to 15 give error 0032h.
// [RULE7] Latch done flag is bit 0 of response byte 9.
// [RULE8] Host polls latch done flag to learn the latch phase ended.
// [RULE9] Monitor selector 09h returns latched position, bytes 12 to 15, low first.
// [RULE10] Latched value is actual motor position at trigger edge.
// [RULE11] On trigger, target becomes latched position plus post-latch distance.
// [RULE12] Latch done flag clears when a new latch positioning starts.
`timescale 1ns/100ps

module ltsm_latch_monitor #(
	parameter int POS_W = 32
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Command fields
	input wire ltsm_pkg::ltsm_cmd_t cmd_in,
	input wire logic [POS_W-1:0] commanded_target_position_in,
	input wire logic [POS_W-1:0] post_latch_distance_in,
	// Configuration
	input wire logic full_closed_in,
	input wire logic serial_abs_scale_in,
	// Position and trigger pins
	input wire logic [POS_W-1:0] actual_position_in,
	input wire ltsm_pkg::ltsm_trig_t trig_in,
	// Response fields
	output logic cmd_error_out,
	output logic [15:0] cmd_error_code_out,
	output logic [3:0] latch_trigger_selector_echo_out,
	output logic [7:0] response_byte9_out,
	output logic [7:0] monitor_sel_echo_out,
	output logic [7:0] monitor_byte_out [4],
	output logic [POS_W-1:0] latched_position_one_out,
	output logic [POS_W-1:0] internal_target_out,
	output logic latch_done_flag_out
);

	// ----------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------
	logic [3:0] trig_meta_q;
	logic [3:0] trig_sync_q;
	logic [3:0] trig_prev_q;
	logic [3:0] rise;
	logic [3:0] fall;
	logic [2:0] sync_fill_q;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			trig_meta_q <= 4'h0;
			trig_sync_q <= 4'h0;
			trig_prev_q <= 4'h0;
			sync_fill_q <= 3'h0;
		end else begin
			trig_meta_q <= trig_in;
			trig_sync_q <= trig_meta_q;
			trig_prev_q <= trig_sync_q;
			sync_fill_q <= {sync_fill_q[1:0], 1'b1};
		end
	end

	// Bit order follows the struct: [3]=input one, [2]=two, [1]=three, [0]=Z
	// Masked until the history holds real pin samples: pins idling high
	// would otherwise show a false edge just after reset
	assign rise = sync_fill_q[2] ? (trig_sync_q & ~trig_prev_q) : 4'h0;
	assign fall = sync_fill_q[2] ? (~trig_sync_q & trig_prev_q) : 4'h0;

	// ----------------------------------------
	// Command check
	// ----------------------------------------
	logic is_latch_cmd;
	logic sel_bad;
	logic sel_no_z;
	logic [15:0] err_d;
	logic [3:0] sel;

	assign sel = cmd_in.latch_trigger_selector;
	assign is_latch_cmd = cmd_in.valid && (cmd_in.type_code == ltsm_pkg::TYPE_LATCH_ABS
		|| cmd_in.type_code == ltsm_pkg::TYPE_LATCH_REL); // RULE1
	assign sel_no_z = (sel == ltsm_pkg::SEL_Z_PHASE) && serial_abs_scale_in; // RULE3
	assign sel_bad = !((sel <= ltsm_pkg::SEL_EXTERNAL_INPUT_THREE_RISE)
		|| (sel >= ltsm_pkg::SEL_EXTERNAL_INPUT_ONE_FALL && sel <= ltsm_pkg::SEL_EXTERNAL_INPUT_THREE_FALL)); // RULE6

	always_comb begin
		err_d = ltsm_pkg::ERR_NONE;
		if (is_latch_cmd && sel_bad) begin
			err_d = ltsm_pkg::ERR_BAD_SELECTOR; // RULE6
		end else if (is_latch_cmd && sel_no_z) begin
			err_d = ltsm_pkg::ERR_NO_Z_PHASE; // RULE3
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			cmd_error_out <= 1'b0;
			cmd_error_code_out <= ltsm_pkg::ERR_NONE;
			latch_trigger_selector_echo_out <= 4'h0;
			monitor_sel_echo_out <= 8'h00;
		end else if (cmd_in.valid) begin
			cmd_error_out <= (err_d != ltsm_pkg::ERR_NONE);
			cmd_error_code_out <= err_d;
			latch_trigger_selector_echo_out <= sel;
			monitor_sel_echo_out <= cmd_in.monitor_sel;
		end
	end

	// ----------------------------------------
	// Trigger selection
	// ----------------------------------------
	logic [3:0] sel_q;
	logic hit;

	// Z phase pin carries the scale Z under full-closed; config kept for clarity
	always_comb begin
		case (sel_q)
			ltsm_pkg::SEL_Z_PHASE: hit = rise[0]; // RULE2
			ltsm_pkg::SEL_EXTERNAL_INPUT_ONE_RISE: hit = rise[3]; // RULE4
			ltsm_pkg::SEL_EXTERNAL_INPUT_TWO_RISE: hit = rise[2]; // RULE4
			ltsm_pkg::SEL_EXTERNAL_INPUT_THREE_RISE: hit = rise[1]; // RULE4
			ltsm_pkg::SEL_EXTERNAL_INPUT_ONE_FALL: hit = fall[3]; // RULE5
			ltsm_pkg::SEL_EXTERNAL_INPUT_TWO_FALL: hit = fall[2]; // RULE5
			ltsm_pkg::SEL_EXTERNAL_INPUT_THREE_FALL: hit = fall[1]; // RULE5
			default: hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Latch sequence
	// ----------------------------------------
	ltsm_pkg::ltsm_state_t state_q;
	logic start;

	assign start = is_latch_cmd && (err_d == ltsm_pkg::ERR_NONE);

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			state_q <= ltsm_pkg::LTSM_IDLE;
			sel_q <= 4'h0;
		end else begin
			case (state_q)
				ltsm_pkg::LTSM_IDLE, ltsm_pkg::LTSM_DONE: begin
					if (start) begin
						state_q <= ltsm_pkg::LTSM_ARMED;
						sel_q <= sel;
					end
				end
				ltsm_pkg::LTSM_ARMED: begin
					if (start) begin
						sel_q <= sel;
					end else if (hit) begin
						state_q <= ltsm_pkg::LTSM_DONE;
					end
				end
				default: state_q <= ltsm_pkg::LTSM_IDLE;
			endcase
		end
	end

	logic capture;
	assign capture = (state_q == ltsm_pkg::LTSM_ARMED) && hit && !start;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			latched_position_one_out <= '0;
		end else if (capture) begin
			latched_position_one_out <= actual_position_in; // RULE10
		end
	end

	// Target defaults to command; overwritten once the trigger lands
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			internal_target_out <= '0;
		end else if (start) begin
			internal_target_out <= commanded_target_position_in;
		end else if (capture) begin
			internal_target_out <= actual_position_in + post_latch_distance_in; // RULE11
		end
	end

	// Restart beats a stale completion so old latches never read as done
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			latch_done_flag_out <= 1'b0;
		end else if (start) begin
			latch_done_flag_out <= 1'b0; // RULE12
		end else if (capture) begin
			latch_done_flag_out <= 1'b1;
		end
	end

	// ----------------------------------------
	// Response fields
	// ----------------------------------------
	always_comb begin
		response_byte9_out = 8'h00;
		response_byte9_out[ltsm_pkg::RESP_BYTE9_LATCH_DONE_BIT] = latch_done_flag_out; // RULE7 RULE8
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mon
			always_ff @(posedge clk_in) begin
				if (!rstn_in) begin
					monitor_byte_out[gi] <= 8'h00;
				end else if (cmd_in.valid) begin
					monitor_byte_out[gi] <= (cmd_in.monitor_sel == ltsm_pkg::MON_SEL_LATCHED_POS)
						? latched_position_one_out[gi*8 +: 8] : 8'h00; // RULE9
				end
			end
		end
	endgenerate

endmodule // ltsm_latch_monitor

// ### testbench/ltsm_latch_monitor_asserts.sv
// Checker for the latch monitor block, bound to its top ports.
// Assumes ltsm_pkg is compiled first.
`timescale 1ns/100ps
module ltsm_asserts #(
	parameter int POS_W = 32
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire ltsm_pkg::ltsm_cmd_t cmd_in,
	input wire logic [POS_W-1:0] post_latch_distance_in,
	input wire logic serial_abs_scale_in,
	input wire logic [POS_W-1:0] actual_position_in,
	input wire logic cmd_error_out,
	input wire logic [15:0] cmd_error_code_out,
	input wire logic [7:0] response_byte9_out,
	input wire logic [7:0] monitor_byte_out [4],
	input wire logic [POS_W-1:0] latched_position_one_out,
	input wire logic [POS_W-1:0] internal_target_out,
	input wire logic latch_done_flag_out
);
	logic lat;
	logic bad;
	logic zerr;
	logic [31:0] mon;
	assign lat = cmd_in.valid && (cmd_in.type_code inside {8'h12, 8'h13});
	assign bad = cmd_in.latch_trigger_selector inside {[4'h4:4'h8], [4'hC:4'hF]};
	assign zerr = cmd_in.latch_trigger_selector == 4'h0 && serial_abs_scale_in;
	assign mon = {monitor_byte_out[3], monitor_byte_out[2], monitor_byte_out[1], monitor_byte_out[0]};
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_start;
		lat && !bad && !zerr;
	endsequence
	AST_BAD_SEL: assert property (lat && bad |=> cmd_error_code_out == 16'h0032)
		else $error("bad selector not refused");
	AST_NO_Z: assert property (lat && !bad && zerr |=> cmd_error_code_out == 16'h005A)
		else $error("Z phase on absolute scale not refused");
	AST_NONLATCH: assert property (cmd_in.valid && !lat |=> !cmd_error_out)
		else $error("selector judged on non-latch type");
	AST_START: assert property (s_start |=> !latch_done_flag_out && !cmd_error_out)
		else $error("start left done flag or error");
	AST_BYTE9: assert property (response_byte9_out == {7'h00, latch_done_flag_out})
		else $error("response byte 9 wrong");
	AST_MON: assert property (cmd_in.valid && cmd_in.monitor_sel == 8'h09
		|=> mon == $past(latched_position_one_out)) else $error("monitor data wrong");
	AST_MON_ZERO: assert property (cmd_in.valid && cmd_in.monitor_sel != 8'h09 |=> mon == 0)
		else $error("monitor data not zero");
	AST_CAPTURE: assert property ($rose(latch_done_flag_out) |->
		latched_position_one_out == $past(actual_position_in) && internal_target_out ==
		$past(actual_position_in) + $past(post_latch_distance_in)) else $error("capture wrong");
endmodule // ltsm_asserts
bind ltsm_latch_monitor ltsm_asserts #(.POS_W(POS_W)) ltsm_asserts_i (.clk_in, .rstn_in,
	.cmd_in, .post_latch_distance_in, .serial_abs_scale_in, .actual_position_in, .cmd_error_out,
	.cmd_error_code_out, .response_byte9_out, .monitor_byte_out, .latched_position_one_out,
	.internal_target_out, .latch_done_flag_out);

// ### testbench/ltsm_host_model.sv
// Host controller model: sends command frames, polls the done flag.
// Assumes the bench calls its tasks hierarchically.
`timescale 1ns/100ps
module ltsm_host_model (
	// Clock
	input wire logic clk_in,
	// Status
	input wire logic latch_done_in,
	// Command frame
	output ltsm_pkg::ltsm_cmd_t cmd_out
);
	initial cmd_out = '0;
	// Idle fields flip so a stale frame never looks fresh
	task automatic send(input logic [7:0] t, input logic [3:0] s, input logic [7:0] m);
		@(posedge clk_in);
		cmd_out <= {1'b1, t, s, m};
		@(posedge clk_in);
		cmd_out <= {1'b0, ~cmd_out[19:0]};
		@(posedge clk_in);
	endtask
	task automatic poll(input int n, output logic hit);
		hit = 1'b0;
		repeat (n) @(posedge clk_in) if (latch_done_in) hit = 1'b1;
	endtask
endmodule // ltsm_host_model

// ### testbench/test_ltsm_latch_monitor.sv
// Bench: latch commands, trigger edges, refusals and monitor readback.
// Assumes the checker and host model are compiled alongside.
`timescale 1ns/100ps
module test_ltsm_latch_monitor;
	logic clk_in = 0, rstn_in = 0, full_closed_in = 0, serial_abs_scale_in = 0, hit;
	logic cmd_error_out, latch_done_flag_out;
	logic [15:0] cmd_error_code_out;
	logic [7:0] response_byte9_out, monitor_byte_out [4];
	logic [31:0] act = 32'h0, latched_position_one_out, internal_target_out;
	logic [3:0] idle, sel_echo;
	logic [7:0] mon_echo;
	logic [3:0] sels [7] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'h0};
	logic [3:0] pin [7] = '{4'h8, 4'h4, 4'h2, 4'h8, 4'h4, 4'h2, 4'h1};
	ltsm_pkg::ltsm_cmd_t cmd;
	ltsm_pkg::ltsm_trig_t trig = '0;
	int mismatches = 0, n_compared = 0;
	initial forever #4 clk_in = ~clk_in;
	ltsm_host_model ltsm_host_model_i (.clk_in, .latch_done_in(latch_done_flag_out), .cmd_out(cmd));
	ltsm_latch_monitor ltsm_latch_monitor_i (.clk_in, .rstn_in, .cmd_in(cmd),
		.commanded_target_position_in(~act), .post_latch_distance_in(32'h0000_0100),
		.full_closed_in, .serial_abs_scale_in, .actual_position_in(act), .trig_in(trig),
		.cmd_error_out, .cmd_error_code_out, .latch_trigger_selector_echo_out(sel_echo),
		.response_byte9_out, .monitor_sel_echo_out(mon_echo), .monitor_byte_out,
		.latched_position_one_out, .internal_target_out, .latch_done_flag_out);
	task automatic chk(input logic [31:0] g, e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#20us;
		mismatches++;
		results();
	end
	initial begin
		repeat (3) @(posedge clk_in);
		rstn_in <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			idle = sels[i][3] ? 4'hF : 4'h0;
			@(posedge clk_in) trig <= idle;
			act <= 32'hA5A5_0000 + i;
			full_closed_in <= (i == 6);
			repeat (4) @(posedge clk_in);
			ltsm_host_model_i.send(8'h12 + i[0], sels[i], 8'h00);
			chk(latch_done_flag_out, 0);
			chk(internal_target_out, ~act);
			trig <= idle ^ {pin[i][0], pin[i][3:1]};
			ltsm_host_model_i.poll(6, hit);
			chk(hit, 0);
			trig <= idle ^ pin[i];
			ltsm_host_model_i.poll(6, hit);
			chk(hit, 1);
			chk(latched_position_one_out, act);
			chk(internal_target_out, act + 32'h0000_0100);
			chk(response_byte9_out, 1);
			ltsm_host_model_i.send(8'h10, 4'h4, 8'h09);
			chk(cmd_error_out, 0);
			chk(sel_echo, 4'h4);
			chk(mon_echo, 8'h09);
			chk({monitor_byte_out[3], monitor_byte_out[2], monitor_byte_out[1], monitor_byte_out[0]}, act);
		end
		for (int s = 4; s < 16; s++) if (s < 9 || s > 11) begin
			serial_abs_scale_in <= s[0];
			ltsm_host_model_i.send(8'h12 + s[0], s[3:0], 8'h00);
			chk(cmd_error_code_out, 16'h0032);
		end
		serial_abs_scale_in <= 1'b1;
		ltsm_host_model_i.send(8'h13, 4'h0, 8'h00);
		chk(cmd_error_code_out, 16'h005A);
		chk(latch_done_flag_out, 1);
		ltsm_host_model_i.send(8'h12, 4'h1, 8'h00);
		chk(latch_done_flag_out, 0);
		// Mid-run reset with pins idling high, then an immediate arm
		@(posedge clk_in) rstn_in <= 1'b0;
		trig <= 4'hF;
		serial_abs_scale_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		rstn_in <= 1'b1;
		ltsm_host_model_i.send(8'h12, 4'h1, 8'h00);
		ltsm_host_model_i.poll(6, hit);
		chk(hit, 0);
		chk(latched_position_one_out, 0);
		results();
	end
endmodule // test_ltsm_latch_monitor
